// [rtl/mmcpg_map_if.sv]
// Bundle between the top and one address mapper.
// Assumes the mapper is purely combinational.
`timescale 1ns/10ps
interface mmcpg_map_if;
    logic [15:0]              local_addr;   // Local address after direct substitution
    logic [3:0]               idx;          // Current page index
    logic                     info_vis;     // Info row shown
    logic [17:0]              global_addr;  // Translated address
    mmcpg_pkg::mmcpg_target_t target;       // Selected resource

    modport requester (output local_addr, idx, info_vis, input global_addr, target);
    modport mapper    (input local_addr, idx, info_vis, output global_addr, target);
endinterface

// [rtl/mmcpg_mapper.sv]
// Local to global translation and resource decode for one master.
// Assumes the requester registers the results.
`timescale 1ns/10ps
module mmcpg_mapper (
    mmcpg_map_if.mapper m  // Map request and result
);
    logic [3:0] page;

    always_comb begin
        page          = mmcpg_pkg::page_of(m.local_addr, m.idx);
        m.global_addr = {page, m.local_addr[13:0]};
        // Only internal resources exist; anything else is unimplemented
        if (m.local_addr <= mmcpg_pkg::REG_LAST) begin
            m.target = mmcpg_pkg::TGT_REG;
        end else if (m.local_addr >= mmcpg_pkg::RAM_FIRST && m.local_addr <= mmcpg_pkg::RAM_LAST) begin
            m.target = mmcpg_pkg::TGT_RAM;
        end else if (m.info_vis && m.global_addr >= mmcpg_pkg::INFO_FIRST
                     && m.global_addr <= mmcpg_pkg::INFO_LAST) begin
            m.target = mmcpg_pkg::TGT_INFO;
        end else if (page >= mmcpg_pkg::FLASH_FIRST) begin
            m.target = mmcpg_pkg::TGT_FLASH;
        end else begin
            m.target = mmcpg_pkg::TGT_NONE;
        end
    end
endmodule

// [rtl/mmcpg_pkg.sv]
// Constants and types shared by the memory map and paging control.
// Assumes a single bus clock and a plain register port with byte-wide data.
//
// Overview of operation
// - Each master's 16-bit local address maps into an 18-bit global space.
// - CPU and debug master are arbitrated; each has its own map path.
// - In single-chip modes a CPU access to no module raises system reset.
// - Works in run and wait; in stop mode ignores register writes and master accesses, but register reads still answer.
// - Mode bit takes the synchronised mode-select input level on the third clock edge after reset releases.
// - Page register at 0x0030 holds index bits 3..0; bits 7..4 read ones.
// - Local 0x8000-0xBFFF from either master goes to the indexed page, which is flash only for index 0xC-0xF.
// - CPU reads and writes the page register on a dedicated call/return path.
// - Local 0x0000-0x3FFF maps to fixed page 0xFC, overlaid by registers and RAM.
// - Local 0x4000-0x7FFF always maps to fixed page 0xFD.
// - Local 0xC000-0xFFFF always maps to fixed page 0xFF.
// - Page register resets to 0xFE giving linear flash out of reset.
// - Direct page register writes freely in special mode, only once in normal.
// - CPU direct addressing takes address bits 15..8 from the direct register.
// - The direct page position holds for local and global mapping alike.
// - Single-chip modes route every access to internal resources only.
// - A disallowed mode write leaves the bit and locks it, except in special.
// - Info row visible at global 0x00400-0x0047F only while its bit is set.
package mmcpg_pkg;

    // -------------------------------------------------------------------------
    // Register offsets
    // -------------------------------------------------------------------------
    localparam logic [7:0]  OFS_PAGE      = 8'h30;
    localparam logic [7:0]  OFS_DIRECT    = 8'h31;
    localparam logic [7:0]  OFS_MODE      = 8'h32;
    localparam logic [7:0]  OFS_MAPCTL    = 8'h33;
    localparam logic [7:0]  OFS_IRQ_STAT  = 8'h34;
    localparam logic [7:0]  OFS_IRQ_CLR   = 8'h35;
    localparam logic [7:0]  OFS_IRQ_EN    = 8'h36;

    // -------------------------------------------------------------------------
    // Reset values and fields
    // -------------------------------------------------------------------------
    localparam logic [7:0]  PAGE_RST      = 8'hFE;
    localparam logic [3:0]  PAGE_UPPER    = 4'hF;
    localparam logic [7:0]  DIRECT_RST    = 8'h00;
    localparam logic        MODE_RST      = 1'b0;
    localparam int          MODE_BIT      = 7;
    localparam int          INFO_BIT      = 0;
    localparam logic [1:0]  BOOT_CAPTURE  = 2'h3;

    // -------------------------------------------------------------------------
    // Local windows and fixed pages
    // -------------------------------------------------------------------------
    localparam logic [1:0]  WIN_FIX0      = 2'h0;
    localparam logic [1:0]  WIN_FIX1      = 2'h1;
    localparam logic [1:0]  WIN_PAGED     = 2'h2;
    localparam logic [7:0]  PAGE_FIX0     = 8'hFC;
    localparam logic [7:0]  PAGE_FIX1     = 8'hFD;
    localparam logic [7:0]  PAGE_FIX3     = 8'hFF;
    localparam logic [15:0] REG_LAST      = 16'h03FF;
    localparam logic [15:0] RAM_FIRST     = 16'h3800;
    localparam logic [15:0] RAM_LAST      = 16'h3FFF;
    localparam logic [3:0]  FLASH_FIRST   = 4'hC;
    localparam logic [17:0] INFO_FIRST    = 18'h00400;
    localparam logic [17:0] INFO_LAST     = 18'h0047F;

    // -------------------------------------------------------------------------
    // Interrupt status bits
    // -------------------------------------------------------------------------
    localparam int          EV_CPU_UNIMP  = 0;
    localparam int          EV_DBG_UNIMP  = 1;
    localparam int          EV_MODE_BLOCK = 2;
    localparam int          EV_DIR_BLOCK  = 3;
    localparam int          EV_COUNT      = 4;

    typedef enum logic [2:0] {
        TGT_NONE  = 3'h0,
        TGT_REG   = 3'h1,
        TGT_RAM   = 3'h2,
        TGT_FLASH = 3'h3,
        TGT_INFO  = 3'h4
    } mmcpg_target_t;

    // Page of a local address: fixed for three windows, programmed for one
    function automatic logic [3:0] page_of(input logic [15:0] a, input logic [3:0] idx);
        logic [3:0] p;
        p = PAGE_FIX3[3:0];
        case (a[15:14])
            WIN_FIX0:  p = PAGE_FIX0[3:0];
            WIN_FIX1:  p = PAGE_FIX1[3:0];
            WIN_PAGED: p = idx;
            default:   p = PAGE_FIX3[3:0];
        endcase
        return p;
    endfunction

endpackage

// [rtl/mmcpg_sync2.sv]
// Two-flop synchroniser for a level from a pin.
// Assumes the input is asynchronous to clock.
`timescale 1ns/10ps
module mmcpg_sync2 (
    input  wire logic clock,  // Bus clock
    input  wire logic rst,    // Async reset, high
    input  wire logic din,    // Pin level
    output logic      dout    // Synchronised level
);
    logic meta_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            dout   <= 1'b0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule

// [rtl/mmcpg_top.sv]
// Memory map and paging control: arbitration of CPU and debug master,
// page and direct registers, mode latch and unimplemented-access reset.
// Assumes masters hold a request for one cycle and accept the grant pulse.
`timescale 1ns/10ps
module mmcpg_top (
    input  wire logic         clock,           // Bus clock, 25 MHz
    input  wire logic         rst,             // Async reset, high
    input  wire logic         stop_mode,       // Device in stop mode
    input  wire logic         mode_select_input, // Mode pin, asynchronous
    // Register port
    input  wire logic [7:0]   reg_addr,        // Register offset
    input  wire logic [7:0]   reg_wdata,       // Write data
    input  wire logic         reg_wr,          // Write strobe
    input  wire logic         reg_rd,          // Read strobe
    output logic      [7:0]   reg_rdata,       // Read data, cycle after strobe
    // CPU master
    input  wire logic         cpu_req,         // Access request
    input  wire logic [15:0]  cpu_addr,        // Local address
    input  wire logic         cpu_direct,      // Direct addressing mode
    output logic              cpu_grant,       // Access taken
    output logic [17:0]       cpu_global_addr, // Translated address
    output logic [2:0]        cpu_target,      // Selected resource
    // Dedicated page path for call and return
    input  wire logic         call_page_wr,    // Page write strobe
    input  wire logic [7:0]   call_page_wdata, // Page write data
    output logic      [7:0]   call_page_rdata, // Page register value
    // Background debug master
    input  wire logic         dbg_req,         // Access request
    input  wire logic [15:0]  dbg_addr,        // Local address
    output logic              dbg_grant,       // Access taken
    output logic [17:0]       dbg_global_addr, // Translated address
    output logic [2:0]        dbg_target,      // Selected resource
    // System
    output logic              sys_reset_req,   // One-cycle reset request
    output logic              normal_mode,     // Mode bit
    output logic              irq              // Level interrupt
);

    // -------------------------------------------------------------------------
    // Register state
    // -------------------------------------------------------------------------
    logic [3:0]                      idx_q;
    logic [7:0]                      direct_q;
    logic                            direct_done_q;
    logic                            mode_q;
    logic                            mode_lock_q;
    logic                            info_vis_q;
    logic [1:0]                      boot_q;
    logic                            mode_pin_s;
    logic [mmcpg_pkg::EV_COUNT-1:0]  stat_q;
    logic [mmcpg_pkg::EV_COUNT-1:0]  stat_d;
    logic [mmcpg_pkg::EV_COUNT-1:0]  en_q;
    logic [mmcpg_pkg::EV_COUNT-1:0]  ev;

    logic wr_page;
    logic wr_direct;
    logic wr_mode;
    logic wr_map;
    logic wr_clr;
    logic wr_en;
    logic direct_block;
    logic mode_block;

    assign wr_page   = reg_wr && !stop_mode && reg_addr == mmcpg_pkg::OFS_PAGE;
    assign wr_direct = reg_wr && !stop_mode && reg_addr == mmcpg_pkg::OFS_DIRECT;
    assign wr_mode   = reg_wr && !stop_mode && reg_addr == mmcpg_pkg::OFS_MODE;
    assign wr_map    = reg_wr && !stop_mode && reg_addr == mmcpg_pkg::OFS_MAPCTL;
    assign wr_clr    = reg_wr && !stop_mode && reg_addr == mmcpg_pkg::OFS_IRQ_CLR;
    assign wr_en     = reg_wr && !stop_mode && reg_addr == mmcpg_pkg::OFS_IRQ_EN;

    // -------------------------------------------------------------------------
    // Mode pin capture
    // -------------------------------------------------------------------------
    mmcpg_sync2 u_mode_sync (
        .clock (clock),
        .rst   (rst),
        .din   (mode_select_input),
        .dout  (mode_pin_s)
    );

    // Waits out both synchroniser flops so the captured level is the pin's, not their reset value
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            boot_q <= 2'h0;
        end else if (boot_q != mmcpg_pkg::BOOT_CAPTURE) begin
            boot_q <= boot_q + 2'h1;
        end
    end

    // Normal mode is 1; only special to normal may be written
    assign mode_block = wr_mode && mode_q && !reg_wdata[mmcpg_pkg::MODE_BIT];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_q      <= mmcpg_pkg::MODE_RST;
            mode_lock_q <= 1'b0;
        end else if (boot_q == mmcpg_pkg::BOOT_CAPTURE - 2'h1) begin
            mode_q      <= mode_pin_s;
        end else if (wr_mode) begin
            if (!mode_q) begin
                mode_q <= reg_wdata[mmcpg_pkg::MODE_BIT];
            end else if (mode_block) begin
                mode_lock_q <= 1'b1;
            end
        end
    end

    // -------------------------------------------------------------------------
    // Page, direct and map control registers
    // -------------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            idx_q <= mmcpg_pkg::PAGE_RST[3:0];
        end else if (call_page_wr && !stop_mode) begin
            idx_q <= call_page_wdata[3:0];
        end else if (wr_page) begin
            idx_q <= reg_wdata[3:0];
        end
    end

    assign direct_block = wr_direct && mode_q && direct_done_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            direct_q      <= mmcpg_pkg::DIRECT_RST;
            direct_done_q <= 1'b0;
        end else if (wr_direct && !direct_block) begin
            direct_q      <= reg_wdata;
            direct_done_q <= 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            info_vis_q <= 1'b0;
        end else if (wr_map) begin
            info_vis_q <= reg_wdata[mmcpg_pkg::INFO_BIT];
        end
    end

    // -------------------------------------------------------------------------
    // Address mapping, one mapper per master
    // -------------------------------------------------------------------------
    mmcpg_map_if cpu_map ();
    mmcpg_map_if dbg_map ();

    always_comb begin
        cpu_map.local_addr = cpu_direct ? {direct_q, cpu_addr[7:0]} : cpu_addr;
        cpu_map.idx        = idx_q;
        cpu_map.info_vis   = info_vis_q;
        dbg_map.local_addr = dbg_addr;
        dbg_map.idx        = idx_q;
        dbg_map.info_vis   = info_vis_q;
    end

    mmcpg_mapper u_cpu_map (
        .m (cpu_map.mapper)
    );

    mmcpg_mapper u_dbg_map (
        .m (dbg_map.mapper)
    );

    // -------------------------------------------------------------------------
    // Arbitration: the debug master wins a shared cycle
    // -------------------------------------------------------------------------
    logic cpu_take;
    logic dbg_take;

    assign dbg_take = dbg_req && !stop_mode;
    assign cpu_take = cpu_req && !stop_mode && !dbg_req;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cpu_grant       <= 1'b0;
            cpu_global_addr <= 18'h00000;
            cpu_target      <= 3'h0;
        end else begin
            cpu_grant <= cpu_take;
            if (cpu_take) begin
                cpu_global_addr <= cpu_map.global_addr;
                cpu_target      <= cpu_map.target;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dbg_grant       <= 1'b0;
            dbg_global_addr <= 18'h00000;
            dbg_target      <= 3'h0;
        end else begin
            dbg_grant <= dbg_take;
            if (dbg_take) begin
                dbg_global_addr <= dbg_map.global_addr;
                dbg_target      <= dbg_map.target;
            end
        end
    end

    // Only CPU misses reset the system; debug misses are just reported
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sys_reset_req <= 1'b0;
        end else begin
            sys_reset_req <= cpu_take && cpu_map.target == mmcpg_pkg::TGT_NONE;
        end
    end

    // -------------------------------------------------------------------------
    // Interrupt status: set wins over clear
    // -------------------------------------------------------------------------
    always_comb begin
        ev                           = '0;
        ev[mmcpg_pkg::EV_CPU_UNIMP]  = cpu_take && cpu_map.target == mmcpg_pkg::TGT_NONE;
        ev[mmcpg_pkg::EV_DBG_UNIMP]  = dbg_take && dbg_map.target == mmcpg_pkg::TGT_NONE;
        ev[mmcpg_pkg::EV_MODE_BLOCK] = mode_block || (wr_mode && mode_lock_q);
        ev[mmcpg_pkg::EV_DIR_BLOCK]  = direct_block;
        stat_d = stat_q;
        if (wr_clr) begin
            stat_d = stat_q & ~reg_wdata[mmcpg_pkg::EV_COUNT-1:0];
        end
        stat_d = stat_d | ev;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stat_q <= '0;
            en_q   <= '0;
            irq    <= 1'b0;
        end else begin
            stat_q <= stat_d;
            if (wr_en) begin
                en_q <= reg_wdata[mmcpg_pkg::EV_COUNT-1:0];
            end
            irq <= |(stat_d & (wr_en ? reg_wdata[mmcpg_pkg::EV_COUNT-1:0] : en_q));
        end
    end

    // -------------------------------------------------------------------------
    // Read path
    // -------------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                mmcpg_pkg::OFS_PAGE:     reg_rdata <= {mmcpg_pkg::PAGE_UPPER, idx_q};
                mmcpg_pkg::OFS_DIRECT:   reg_rdata <= direct_q;
                mmcpg_pkg::OFS_MODE:     reg_rdata <= {mode_q, 7'h00};
                mmcpg_pkg::OFS_MAPCTL:   reg_rdata <= {7'h00, info_vis_q};
                mmcpg_pkg::OFS_IRQ_STAT: reg_rdata <= {4'h0, stat_q};
                mmcpg_pkg::OFS_IRQ_EN:   reg_rdata <= {4'h0, en_q};
                default:                 reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            call_page_rdata <= mmcpg_pkg::PAGE_RST;
            normal_mode     <= mmcpg_pkg::MODE_RST;
        end else begin
            call_page_rdata <= {mmcpg_pkg::PAGE_UPPER, idx_q};
            normal_mode     <= mode_q;
        end
    end

endmodule

// [sim/memory_map_paging_control_tb.sv]
// Testbench for the paging control: register port, two masters.
// Assumes the master models and the port checker beside it.
`timescale 1ns/10ps
module memory_map_paging_control_tb;
    logic clock = 0, rst = 1, stop_mode = 0, mode_select_input = 1;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, call_page_wdata = 0, call_page_rdata;
    logic reg_wr = 0, reg_rd = 0, cpu_direct = 0, call_page_wr = 0, cpu_start = 0, dbg_start = 0;
    logic cpu_req, dbg_req, cpu_grant, dbg_grant, sys_reset_req, normal_mode, irq, cpu_busy, dbg_busy;
    logic [15:0] cpu_addr, dbg_addr, cpu_sa = 0, dbg_sa = 0;
    logic [17:0] cpu_global_addr, dbg_global_addr;
    logic [2:0] cpu_target, dbg_target;
    logic [15:0] tab [6] = '{16'h0010, 16'h3900, 16'h1234, 16'h4567, 16'hA123, 16'hC00F};
    int failures = 0, total_checks = 0;

    always #20 clock = ~clock;

    mmcpg_top u_mmcpg_top (.*);
    mmcpg_master_model u_cpu_m (.clock(clock), .rst(rst), .start(cpu_start), .start_addr(cpu_sa),
        .grant(cpu_grant), .req(cpu_req), .addr(cpu_addr), .busy(cpu_busy));
    mmcpg_master_model u_dbg_m (.clock(clock), .rst(rst), .start(dbg_start), .start_addr(dbg_sa),
        .grant(dbg_grant), .req(dbg_req), .addr(dbg_addr), .busy(dbg_busy));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [39:0] s, input logic [39:0] e);
        total_checks++;
        if (s !== e) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic print_verdict();
        if (failures == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic go(input logic cs, input logic ds, input logic [15:0] ca, input logic [15:0] da,
                      input logic dir);
        @(posedge clock);
        cpu_start <= cs;
        dbg_start <= ds;
        cpu_sa <= ca;
        dbg_sa <= da;
        cpu_direct <= dir;
        @(posedge clock);
        cpu_start <= 1'b0;
        dbg_start <= 1'b0;
        repeat (20) begin
            #1 if (!cpu_busy && !dbg_busy) break;
            @(posedge clock);
        end
        chk({cpu_busy, dbg_busy}, 0);
    endtask
    task automatic do_reset(input logic m);
        mode_select_input <= m;
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
        #1;
    endtask
    function automatic logic [17:0] gexp(input logic [15:0] a, input logic [3:0] idx);
        logic [3:0] p;
        p = (a[15:14] == 2'h0) ? 4'hC : (a[15:14] == 2'h1) ? 4'hD : (a[15:14] == 2'h2) ? idx : 4'hF;
        return {p, a[13:0]};
    endfunction
    function automatic logic [2:0] texp(input logic [15:0] a, input logic [3:0] idx);
        logic [17:0] g;
        g = gexp(a, idx);
        if (a <= 16'h03FF) return 3'h1;
        if (a >= 16'h3800 && a <= 16'h3FFF) return 3'h2;
        return (g[17:14] >= 4'hC) ? 3'h3 : 3'h0;
    endfunction

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        do_reset(1'b1);
        chk(normal_mode, 1);
        rd_reg(8'h30, 8'hFE);
        chk(call_page_rdata, 8'hFE);
        rd_reg(8'h32, 8'h80);
        rd_reg(8'h40, 8'h00);
        wr_reg(8'h36, 8'h0F);
        for (int i = 0; i < 6; i++) begin
            go(1, 0, tab[i], 0, 0);
            chk(cpu_global_addr, gexp(tab[i], 4'hE));
            chk(cpu_target, texp(tab[i], 4'hE));
            go(0, 1, 0, tab[i], 0);
            chk(dbg_global_addr, gexp(tab[i], 4'hE));
        end
        wr_reg(8'h30, 8'hA3);
        rd_reg(8'h30, 8'hF3);
        go(1, 0, 16'hA123, 0, 0);
        chk(cpu_global_addr, 18'h0E123);
        rd_reg(8'h34, 8'h01);
        chk(irq, 1);
        wr_reg(8'h35, 8'h01);
        rd_reg(8'h34, 8'h00);
        chk(irq, 0);
        go(1, 1, 16'h4567, 16'hC00F, 0);
        chk({cpu_global_addr, dbg_global_addr}, {18'h34567, 18'h3C00F});
        @(posedge clock);
        call_page_wr <= 1'b1;
        call_page_wdata <= 8'h07;
        @(posedge clock);
        call_page_wr <= 1'b0;
        @(posedge clock);
        #1 chk(call_page_rdata, 8'hF7);
        rd_reg(8'h30, 8'hF7);
        wr_reg(8'h31, 8'h80);
        wr_reg(8'h31, 8'h11);
        rd_reg(8'h31, 8'h80);
        go(1, 0, 16'h0045, 0, 1);
        chk(cpu_global_addr, gexp(16'h8045, 4'h7));
        wr_reg(8'h32, 8'h00);
        rd_reg(8'h32, 8'h80);
        rd_reg(8'h34, 8'h0D);
        wr_reg(8'h35, 8'h0F);
        wr_reg(8'h36, 8'h00);
        wr_reg(8'h32, 8'h80);
        rd_reg(8'h34, 8'h04);
        chk(irq, 0);
        @(posedge clock);
        stop_mode <= 1'b1;
        wr_reg(8'h30, 8'h05);
        stop_mode <= 1'b0;
        rd_reg(8'h30, 8'hF7);
        do_reset(1'b0);
        chk(normal_mode, 0);
        wr_reg(8'h31, 8'h22);
        wr_reg(8'h31, 8'h33);
        rd_reg(8'h31, 8'h33);
        wr_reg(8'h30, 8'h00);
        go(0, 1, 0, 16'h8400, 0);
        chk(dbg_target, 3'h0);
        wr_reg(8'h33, 8'h01);
        go(0, 1, 0, 16'h8400, 0);
        chk({dbg_global_addr, dbg_target}, {18'h00400, 3'h4});
        print_verdict();
    end

    initial begin
        #200000;
        failures++;
        print_verdict();
    end
endmodule

// [sim/mmcpg_master_model.sv]
// Request model for one bus master of the paging control.
// Assumes the grant comes the cycle after the request is taken.
`timescale 1ns/10ps
module mmcpg_master_model (
    input  wire logic        clock,      // Bus clock
    input  wire logic        rst,        // Async reset
    input  wire logic        start,      // Begin an access
    input  wire logic [15:0] start_addr, // Address to send
    input  wire logic        grant,      // Access taken
    output logic             req,        // Request pulse
    output logic [15:0]      addr,       // Request address
    output logic             busy        // Access open
);
    logic [15:0] held_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            req <= 1'b0;
            addr <= 16'h0000;
            busy <= 1'b0;
            held_q <= 16'h0000;
        end else if (start && !busy) begin
            req <= 1'b1;
            addr <= start_addr;
            held_q <= start_addr;
            busy <= 1'b1;
        end else if (req) begin
            // Idle address shows no stale value
            req <= 1'b0;
            addr <= ~held_q;
        end else if (busy && grant) begin
            busy <= 1'b0;
        end else if (busy) begin
            // Lost arbitration: ask again
            req <= 1'b1;
            addr <= held_q;
        end
    end
endmodule

// [sim/mmcpg_properties.sv]
// Port checks for the paging control.
// Assumes one bus clock and the async high reset.
`timescale 1ns/10ps
module mmcpg_properties (
    input wire logic        clock,           // Bus clock
    input wire logic        rst,             // Reset
    input wire logic        stop_mode,       // Stop
    input wire logic [7:0]  reg_addr,        // Offset
    input wire logic        reg_wr,          // Write
    input wire logic        reg_rd,          // Read
    input wire logic [7:0]  reg_rdata,       // Read data
    input wire logic        cpu_req,         // CPU request
    input wire logic [15:0] cpu_addr,        // CPU address
    input wire logic        cpu_direct,      // Direct mode
    input wire logic        cpu_grant,       // CPU grant
    input wire logic [17:0] cpu_global_addr, // CPU global
    input wire logic [2:0]  cpu_target,      // CPU target
    input wire logic        call_page_wr,    // Call write
    input wire logic [7:0]  call_page_wdata, // Call data
    input wire logic [7:0]  call_page_rdata, // Call read
    input wire logic        dbg_req,         // Debug request
    input wire logic        dbg_grant,       // Debug grant
    input wire logic        sys_reset_req    // Reset request
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    wire take = cpu_req && !dbg_req && !stop_mode && !cpu_direct;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    AST_CPU_GRANT: assert property (cpu_req && !dbg_req && !stop_mode |=> cpu_grant)
        else $error("CPU request not granted");
    AST_DBG_WINS: assert property (dbg_req && !stop_mode |=> dbg_grant && !cpu_grant)
        else $error("Debug master did not win");
    AST_STOP_IDLE: assert property (stop_mode |=> !cpu_grant && !dbg_grant && !sys_reset_req)
        else $error("Access taken in stop");
    AST_PAGE_UPPER: assert property (reg_rd && reg_addr == 8'h30 |=> reg_rdata[7:4] == 4'hF)
        else $error("Page upper bits not ones");
    AST_UNIMP_RESET: assert property (cpu_grant && cpu_target == 3'h0 |-> sys_reset_req)
        else $error("No reset on unmapped access");
    AST_RESET_CAUSE: assert property (sys_reset_req |-> cpu_grant && cpu_target == 3'h0)
        else $error("Reset without unmapped access");
    AST_FIX_LOW: assert property (take && cpu_addr[15:14] == 2'h0 |=> cpu_global_addr[17:14] == 4'hC)
        else $error("Low window page wrong");
    AST_FIX_MID: assert property (take && cpu_addr[15:14] == 2'h1 |=> cpu_global_addr[17:14] == 4'hD)
        else $error("Middle window page wrong");
    AST_FIX_TOP: assert property (take && cpu_addr[15:14] == 2'h3 |=> cpu_global_addr[17:14] == 4'hF)
        else $error("Top window page wrong");
    AST_LOW_BITS: assert property (take |=> cpu_global_addr[13:0] == $past(cpu_addr[13:0]))
        else $error("Offset bits not carried");
    AST_CALL_PATH: assert property (call_page_wr && !stop_mode ##1 !call_page_wr && !reg_wr
        |=> call_page_rdata == {4'hF, $past(call_page_wdata[3:0], 2)})
        else $error("Call path write lost");

    cover property (cpu_req && dbg_req);
    cover property (sys_reset_req);
    cover property (call_page_wr);
endmodule

bind mmcpg_top mmcpg_properties u_props (.*);
